/* sram_tap_cfg.svh */
// Constants of the boundary-scan test port
`ifndef SRAM_TAP_CFG_SVH
`define SRAM_TAP_CFG_SVH

// ----------------------------------------------------------------
// Register lengths
// ----------------------------------------------------------------
`define IR_LEN        3
`define BYPASS_LEN    1
`define IDENT_LEN     32
`define BSR_LEN       71

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define OP_EXTEST     3'h0
`define OP_IDENT      3'h1
`define OP_SAMPLE_Z   3'h2
`define OP_SAMPLE     3'h4
`define OP_BYPASS     3'h7

// ----------------------------------------------------------------
// Capture values and field positions
// ----------------------------------------------------------------
`define IR_CAPTURE    3'h1
`define BYPASS_RESET  1'h0
`define ID_PRESENT_BIT 0
`define ID_REV_LSB    29
`define ID_DEPTH_LSB  24
`define ID_TYPE_LSB   18
`define ID_DEV_LSB    12
`define ID_MAKER_LSB  1

`endif

/* tap_pkg.sv */
// Types shared by the boundary-scan test port
package tap_pkg;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  // ----------------------------------------------------------------
  // Data register selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DR_BYPASS, DR_IDENT, DR_BOUNDARY
  } dr_sel_t;

  // ----------------------------------------------------------------
  // Identification word layout, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  revision;
    logic [4:0]  depth;
    logic [5:0]  mem_type;
    logic [5:0]  device;
    logic [10:0] maker;
    logic        present;
  } ident_word_t;

endpackage : tap_pkg

/* tap_state_ctrl.sv */
// Sixteen-state test port controller
`timescale 1ns/1ps
`include "sram_tap_cfg.svh"

module tap_state_ctrl
  import tap_pkg::*;
(
  // Test clock and reset
  input  wire logic       tck,
  input  wire logic       tap_rst,
  // Mode select and state
  input  wire logic       tms,
  output tap_state_t      state
);

  tap_state_t next_state;

  // (R15) state walk
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET:    next_state = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     next_state = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   next_state = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   next_state = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
      default:     next_state = ST_RESET;
    endcase
  end

  // (R11) mode select taken on rising edge
  always_ff @(posedge tck or posedge tap_rst)
  begin
    if (tap_rst)
      state <= ST_RESET;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence tms_held_five;
    tms [*5];
  endsequence

  five_high_reset_a : assert property (  // (R15)
    @(posedge tck) disable iff (tap_rst)
    tms_held_five |=> state == ST_RESET)
    else $error("five high mode selects did not reach reset");

  ir_path_a : assert property (  // (R15)
    @(posedge tck) disable iff (tap_rst)
    (state == ST_SEL_IR && !tms) ##1 !tms |=> state == ST_SHIFT_IR)
    else $error("instruction path did not reach shift");

endmodule : tap_state_ctrl

/* sram_tap.sv */
// Boundary-scan test port of the synchronous memory
//
// How it works
// (R1) After capture, entering shift-data connects the 71-bit boundary chain to the test port.
// (R2) In one shift-data pass new bits enter from TDI while captured bits leave on TDO.
// (R3) With the bypass instruction, shift-data passes through the one-bit bypass stage.
// (R4) The test controller must not load the reserved codes; they fall back to bypass here.
// (R5) Lengths are 3 (instruction), 1 (bypass), 32 (identification) and 71 (boundary).
// (R6) Identification bit 0 always reads 1.
// (R7) Identification bits 31:29 hold a hardwired revision number.
// (R8) Bits 28:24 hold a depth code and bits 23:18 a memory type and architecture code.
// (R9) Bits 17:12 hold a device code and bits 11:1 the maker code.
// (R10) The test controller ignores captured clock bits if the memory clock ran on.
// (R11) TDI and TMS are taken on rising test clock edges, TDO changes on falling ones.
// (R12) Power-up and the test-logic-reset state load the identify instruction.
// (R13) Capture-instruction loads binary 01 into the two low instruction bits.
// (R14) Code 111 selects bypass and 001 identification, neither touching the memory.
// (R15) A standard sixteen-state controller walks on TMS at each rising test clock edge.
// (R16) A new instruction takes effect only on entering update-instruction; here it loads on the rising edge that leaves update-instruction.
`timescale 1ns/1ps
`include "sram_tap_cfg.svh"

module sram_tap
  import tap_pkg::*;
#(
  parameter int          BSR_LEN     = `BSR_LEN,
  // Identification values below are arbitrary
  parameter logic [2:0]  REVISION    = 3'h2,
  parameter logic [4:0]  DEPTH_CODE  = 5'h05,
  parameter logic [5:0]  TYPE_CODE   = 6'h11,
  parameter logic [5:0]  DEVICE_CODE = 6'h21,
  parameter logic [10:0] MAKER_CODE  = 11'h2A5
)
(
  // System side
  input  wire logic               SYS_CLK,
  input  wire logic               RST,
  input  wire logic               SYS_CE,
  input  wire logic [BSR_LEN-1:0] IO_RING,
  output      logic               OUTPUTS_HIZ,
  // Test port
  input  wire logic               TCK,
  input  wire logic               TMS,
  input  wire logic               TDI,
  output      logic               TDO,
  output      logic               TDO_OE
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // (R5) fixed chain lengths
  if (BSR_LEN != `BSR_LEN)
    $error("boundary chain length must be 71");
  if ($bits(ident_word_t) != `IDENT_LEN)
    $error("identification word must be 32 bits");

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // (R14) code to data register
  function automatic dr_sel_t decode_dr(input logic [`IR_LEN-1:0] op);
    case (op)
      `OP_IDENT:    decode_dr = DR_IDENT;
      `OP_BYPASS:   decode_dr = DR_BYPASS;
      `OP_EXTEST,
      `OP_SAMPLE_Z,
      `OP_SAMPLE:   decode_dr = DR_BOUNDARY;
      // (R4) reserved codes fall back
      default:      decode_dr = DR_BYPASS;
    endcase
  endfunction : decode_dr

  function automatic logic drives_hiz(input logic [`IR_LEN-1:0] op);
    drives_hiz = (op == `OP_EXTEST) || (op == `OP_SAMPLE_Z);
  endfunction : drives_hiz

  // ----------------------------------------------------------------
  // Test clock reset
  // ----------------------------------------------------------------
  logic rst_meta;
  logic tap_rst;

  always_ff @(posedge TCK or posedge RST)
  begin
    if (RST)
    begin
      rst_meta <= 1'b1;
      tap_rst  <= 1'b1;
    end
    else
    begin
      rst_meta <= 1'b0;
      tap_rst  <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  tap_state_t state;

  tap_state_ctrl u_ctrl (
    .tck     (TCK),
    .tap_rst (tap_rst),
    .tms     (TMS),
    .state   (state)
  );

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [`IR_LEN-1:0] ir_shift;
  logic [`IR_LEN-1:0] instr;
  logic               hiz_level;
  logic [`IR_LEN-1:0] next_ir_shift;
  logic [`IR_LEN-1:0] next_instr;
  logic               next_hiz_level;
  dr_sel_t            sel;

  always_comb
  begin
    next_ir_shift = ir_shift;
    next_instr    = instr;
    case (state)
      // (R12) identify on reset
      ST_RESET:    next_instr = `OP_IDENT;
      // (R13) capture pattern
      ST_CAP_IR:   next_ir_shift = `IR_CAPTURE;
      ST_SHIFT_IR: next_ir_shift = {TDI, ir_shift[`IR_LEN-1:1]};
      // (R16) instruction takes effect
      ST_UPD_IR:   next_instr = ir_shift;
      default:     ;
    endcase
    next_hiz_level = drives_hiz(next_instr);
  end

  always_ff @(posedge TCK or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      ir_shift  <= `IR_CAPTURE;
      instr     <= `OP_IDENT;
      hiz_level <= 1'b0;
    end
    else
    begin
      ir_shift  <= next_ir_shift;
      instr     <= next_instr;
      hiz_level <= next_hiz_level;
    end
  end

  assign sel = decode_dr(instr);

  // ----------------------------------------------------------------
  // Ring snapshot handshake, test clock side
  // ----------------------------------------------------------------
  logic [BSR_LEN-1:0] snapshot;
  logic               req_toggle;
  logic               req_meta;
  logic               req_sync;
  logic               ack_toggle;
  logic [BSR_LEN-1:0] ring_copy;
  logic               next_ack_toggle;
  logic [BSR_LEN-1:0] next_ring_copy;

  always_comb
  begin
    next_ack_toggle = ack_toggle;
    next_ring_copy  = ring_copy;
    if (req_sync != ack_toggle)
    begin
      next_ring_copy  = snapshot;
      next_ack_toggle = req_sync;
    end
  end

  always_ff @(posedge TCK or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      req_meta   <= 1'b0;
      req_sync   <= 1'b0;
      ack_toggle <= 1'b0;
      ring_copy  <= '0;
    end
    else
    begin
      req_meta   <= req_toggle;
      req_sync   <= req_meta;
      ack_toggle <= next_ack_toggle;
      ring_copy  <= next_ring_copy;
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  logic                bypass_bit;
  logic [`IDENT_LEN-1:0] ident_shift;
  logic [BSR_LEN-1:0]  bsr;
  logic                next_bypass_bit;
  logic [`IDENT_LEN-1:0] next_ident_shift;
  logic [BSR_LEN-1:0]  next_bsr;
  ident_word_t         ident_word;

  // (R6) presence bit
  // (R7) revision field
  // (R8) depth and type fields
  // (R9) device and maker fields
  assign ident_word = '{revision: REVISION, depth: DEPTH_CODE,
                        mem_type: TYPE_CODE, device: DEVICE_CODE,
                        maker: MAKER_CODE, present: 1'b1};

  always_comb
  begin
    next_bypass_bit  = bypass_bit;
    next_ident_shift = ident_shift;
    next_bsr         = bsr;
    if (state == ST_CAP_DR)
    begin
      case (sel)
        DR_BYPASS:   next_bypass_bit  = `BYPASS_RESET;
        DR_IDENT:    next_ident_shift = ident_word;
        DR_BOUNDARY: next_bsr         = ring_copy;
        default:     ;
      endcase
    end
    else if (state == ST_SHIFT_DR)
    begin
      case (sel)
        // (R3) one-stage path
        DR_BYPASS:   next_bypass_bit  = TDI;
        DR_IDENT:    next_ident_shift = {TDI,
                                         ident_shift[`IDENT_LEN-1:1]};
        // (R2) shift in while out
        DR_BOUNDARY: next_bsr         = {TDI, bsr[BSR_LEN-1:1]};
        default:     ;
      endcase
    end
  end

  always_ff @(posedge TCK or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      bypass_bit  <= `BYPASS_RESET;
      ident_shift <= '0;
      bsr         <= '0;
    end
    else
    begin
      bypass_bit  <= next_bypass_bit;
      ident_shift <= next_ident_shift;
      bsr         <= next_bsr;
    end
  end

  // ----------------------------------------------------------------
  // Serial output on falling edge
  // ----------------------------------------------------------------
  logic tdo_bit;
  logic tdo_en;
  logic next_tdo_bit;
  logic next_tdo_en;

  always_comb
  begin
    next_tdo_bit = tdo_bit;
    next_tdo_en  = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
    if (state == ST_SHIFT_IR)
      next_tdo_bit = ir_shift[0];
    else if (state == ST_SHIFT_DR)
    begin
      case (sel)
        DR_BYPASS:   next_tdo_bit = bypass_bit;
        DR_IDENT:    next_tdo_bit = ident_shift[0];
        // (R1) boundary chain on the port
        DR_BOUNDARY: next_tdo_bit = bsr[0];
        default:     next_tdo_bit = bypass_bit;
      endcase
    end
  end

  // (R11) output moves on falling edge
  always_ff @(negedge TCK or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      tdo_bit <= 1'b0;
      tdo_en  <= 1'b0;
    end
    else
    begin
      tdo_bit <= next_tdo_bit;
      tdo_en  <= next_tdo_en;
    end
  end

  assign TDO    = tdo_bit;
  assign TDO_OE = tdo_en;

  // ----------------------------------------------------------------
  // System clock side
  // ----------------------------------------------------------------
  logic [BSR_LEN-1:0] io_meta;
  logic [BSR_LEN-1:0] io_sync;
  logic               ack_meta;
  logic               ack_sync;
  logic               hiz_meta;
  logic               hiz_sync;
  logic [BSR_LEN-1:0] next_snapshot;
  logic               next_req_toggle;

  // New snapshot only once the last one was taken
  always_comb
  begin
    next_snapshot   = snapshot;
    next_req_toggle = req_toggle;
    if (ack_sync == req_toggle)
    begin
      next_snapshot   = io_sync;
      next_req_toggle = ~req_toggle;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      io_meta    <= '0;
      io_sync    <= '0;
      ack_meta   <= 1'b0;
      ack_sync   <= 1'b0;
      hiz_meta   <= 1'b0;
      hiz_sync   <= 1'b0;
      snapshot   <= '0;
      req_toggle <= 1'b0;
    end
    else if (SYS_CE)
    begin
      io_meta    <= IO_RING;
      io_sync    <= io_meta;
      ack_meta   <= ack_toggle;
      ack_sync   <= ack_meta;
      hiz_meta   <= hiz_level;
      hiz_sync   <= hiz_meta;
      snapshot   <= next_snapshot;
      req_toggle <= next_req_toggle;
    end
  end

  assign OUTPUTS_HIZ = hiz_sync;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence bsr_capture_then_shift;
    (state == ST_CAP_DR && sel == DR_BOUNDARY) ##1 state == ST_SHIFT_DR;
  endsequence

  reset_ident_a : assert property (  // (R12)
    @(posedge TCK) disable iff (tap_rst)
    state == ST_RESET |=> instr == `OP_IDENT)
    else $error("reset did not load the identify instruction");

  ir_capture_a : assert property (  // (R13)
    @(posedge TCK) disable iff (tap_rst)
    state == ST_CAP_IR |=> ir_shift[1:0] == 2'h1)
    else $error("capture did not load 01");

  ir_hold_a : assert property (  // (R16)
    @(posedge TCK) disable iff (tap_rst)
    (state != ST_UPD_IR && state != ST_RESET) |=> $stable(instr))
    else $error("instruction changed outside update");

  ir_update_a : assert property (  // (R16)
    @(posedge TCK) disable iff (tap_rst)
    state == ST_UPD_IR |=> instr == $past(ir_shift))
    else $error("update did not apply shifted code");

  ident_fields_a : assert property (  // (R6)
    @(posedge TCK) disable iff (tap_rst)
    (state == ST_CAP_DR && sel == DR_IDENT) |=>
      ident_shift[`ID_PRESENT_BIT] == 1'b1 &&
      ident_shift[31:`ID_REV_LSB] == REVISION &&
      ident_shift[`ID_DEV_LSB+5:`ID_DEV_LSB] == DEVICE_CODE)
    else $error("identification word wrong after capture");

  bsr_shift_a : assert property (  // (R2)
    @(posedge TCK) disable iff (tap_rst)
    bsr_capture_then_shift |=>
      bsr[BSR_LEN-1] == $past(TDI) &&
      bsr[BSR_LEN-2:0] == $past(bsr[BSR_LEN-1:1]))
    else $error("boundary chain did not shift");

  bsr_out_a : assert property (  // (R1)
    @(negedge TCK) disable iff (tap_rst)
    (state == ST_SHIFT_DR && sel == DR_BOUNDARY) |=>
      tdo_bit == $past(bsr[0]) && tdo_en)
    else $error("boundary chain not on the serial output");

  bypass_path_a : assert property (  // (R3)
    @(posedge TCK) disable iff (tap_rst)
    (state == ST_SHIFT_DR && sel == DR_BYPASS) |=>
      bypass_bit == $past(TDI))
    else $error("bypass stage did not take the input");

  hiz_cross_a : assert property (  // (R14)
    @(posedge SYS_CLK) disable iff (RST)
    (SYS_CE && instr == `OP_BYPASS) [*4] |-> !OUTPUTS_HIZ)
    else $error("bypass disturbed the memory outputs");

endmodule : sram_tap

/* tap_master.sv */
// Board test controller model driving the scan port
`timescale 1ns/1ps

module tap_master
(
  // Scan port
  output logic        tck,
  output logic        tms,
  output logic        tdi,
  input  wire logic   tdo,
  input  wire logic   tdo_oe,
  // Result of each scan, enable flag above the bits
  output logic        res_rdy,
  output logic [80:0] res
);
  localparam int HALF = 16;

  // Clock still, pulled-up lines idle high
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    res_rdy = 1'b0;
    res = '0;
  end

  // ----------------------------------------------------------------
  // One test clock period
  // ----------------------------------------------------------------
  // change while clock low
  task automatic step(input logic m, input logic d,
                      output logic o, output logic e);
    tms = m;
    tdi = d;
    #(HALF / 2);
    // Released output reads as the inverse, so early release shows
    o = tdo_oe ? tdo : ~tdo;
    e = tdo_oe;
    #(HALF / 2);
    tck = 1'b1;
    #HALF;
    tck = 1'b0;
  endtask : step

  task automatic clocks(input int n, input logic m);
    logic o;
    logic e;
    repeat (n) step(m, 1'b1, o, e);
    tdi = 1'b1;
  endtask : clocks

  // ----------------------------------------------------------------
  // Full scan from idle back to idle
  // ----------------------------------------------------------------
  // standard walk through capture, shift, exit, update
  task automatic scan(input logic ir, input int n, input logic [79:0] din);
    logic        o;
    logic        e;
    logic        oe_all;
    logic [79:0] dout;
    dout = '0;
    oe_all = 1'b1;
    step(1'b1, 1'b1, o, e);
    if (ir)
      step(1'b1, 1'b1, o, e);
    step(1'b0, 1'b1, o, e);
    step(1'b0, 1'b1, o, e);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o, e);
      dout[i] = o;
      oe_all = oe_all & e;
    end
    step(1'b1, 1'b1, o, e);
    step(1'b0, 1'b1, o, e);
    tdi = 1'b1;
    res = {oe_all & ~e, dout};
    res_rdy = 1'b1;
    #1;
    res_rdy = 1'b0;
  endtask : scan

endmodule : tap_master

/* sram_tap_tb.sv */
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
`include "sram_tap_cfg.svh"

module sram_tap_tb
  import tap_pkg::*;
;
  // Identification values below are arbitrary
  localparam logic [2:0]  REV   = 3'h5;
  localparam logic [4:0]  DEPTH = 5'h1A;
  localparam logic [5:0]  TYP   = 6'h2C;
  localparam logic [5:0]  DEV   = 6'h13;
  localparam logic [10:0] MAKER = 11'h4B6;
  localparam int          RL    = `BSR_LEN;

  logic          sys_clk;
  logic          rst;
  logic          sys_ce;
  logic [RL-1:0] io_ring;
  logic          outputs_hiz;
  logic          tck;
  logic          tms;
  logic          tdi;
  logic          tdo;
  logic          tdo_oe;
  logic          res_rdy;
  logic [80:0]   res;
  logic [80:0]   exp_q[$];
  logic [79:0]   d;
  logic [2:0]    byp[4];
  logic [2:0]    cap[3];
  ident_word_t   id_exp;
  int            failures;
  int            compares;

  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    sys_ce = 1'b1;
    io_ring = '0;
    failures = 0;
    compares = 0;
  end

  always #12.5 sys_clk = ~sys_clk;

  sram_tap #(
    .REVISION    (REV),
    .DEPTH_CODE  (DEPTH),
    .TYPE_CODE   (TYP),
    .DEVICE_CODE (DEV),
    .MAKER_CODE  (MAKER)
  ) i_sram_tap (
    .SYS_CLK     (sys_clk),
    .RST         (rst),
    .SYS_CE      (sys_ce),
    .IO_RING     (io_ring),
    .OUTPUTS_HIZ (outputs_hiz),
    .TCK         (tck),
    .TMS         (tms),
    .TDI         (tdi),
    .TDO         (tdo),
    .TDO_OE      (tdo_oe)
  );

  tap_master i_tap_master (
    .tck     (tck),
    .tms     (tms),
    .tdi     (tdi),
    .tdo     (tdo),
    .tdo_oe  (tdo_oe),
    .res_rdy (res_rdy),
    .res     (res)
  );

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input logic [80:0] seen, input logic [80:0] want);
    compares++;
    if (seen !== want)
    begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict;
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // Register bits first, then what entered on the serial input
  function automatic logic [80:0] exp_of(input logic [79:0] rv,
      input int len, input int n, input logic [79:0] din);
    logic [79:0] v;
    v = (din << len) | (rv & ((80'h1 << len) - 80'h1));
    v = v & ((80'h1 << n) - 80'h1);
    return {1'b1, v};
  endfunction : exp_of

  function automatic logic [79:0] rnd();
    logic [95:0] t;
    t = {$urandom, $urandom, $urandom};
    return t[79:0];
  endfunction : rnd

  always @(posedge res_rdy)
  begin
    if (exp_q.size() == 0)
    begin
      failures++;
      $display("CHECK FAILED %0t unexpected scan result", $time);
    end
    else
      check(res, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic dr(input logic [79:0] rv, input int len, input int n);
    d = rnd();
    exp_q.push_back(exp_of(rv, len, n, d));
    i_tap_master.scan(1'b0, n, d);
  endtask : dr

  task automatic load_ir(input logic [2:0] code);
    exp_q.push_back(exp_of(80'(`IR_CAPTURE), 3, 3, 80'(code)));
    i_tap_master.scan(1'b1, 3, 80'(code));
  endtask : load_ir

  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    fork
      repeat (4) @(posedge sys_clk);
      i_tap_master.clocks(3, 1'b1);
    join
    rst <= 1'b0;
    i_tap_master.clocks(3, 1'b1);
    i_tap_master.clocks(1, 1'b0);
  endtask : do_reset

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(48012));
    id_exp = '{REV, DEPTH, TYP, DEV, MAKER, 1'b1};
    // reserved codes are never loaded by the controller
    byp = '{`OP_BYPASS, `OP_BYPASS, `OP_BYPASS, `OP_BYPASS};
    cap = '{`OP_EXTEST, `OP_SAMPLE_Z, `OP_SAMPLE};
    do_reset();
    // Identify word after power-up, extra bits prove the length
    dr(80'(id_exp), `IDENT_LEN, 40);
    // One-stage path, system enable wandering meanwhile
    foreach (byp[k])
    begin
      load_ir(byp[k]);
      dr(80'(`BYPASS_RESET), `BYPASS_LEN, 8);
      @(posedge sys_clk);
      sys_ce <= 1'($urandom);
    end
    @(posedge sys_clk);
    sys_ce <= 1'b1;
    // Five high mode bits return to identify
    i_tap_master.clocks(5, 1'b1);
    i_tap_master.clocks(1, 1'b0);
    dr(80'(id_exp), `IDENT_LEN, 40);
    foreach (cap[k])
    begin
      // ring held still, so every bit is compared
      d = rnd();
      @(posedge sys_clk);
      io_ring <= d[RL-1:0];
      load_ir(cap[k]);
      i_tap_master.clocks(12, 1'b0);
      @(negedge sys_clk);
      check(81'(outputs_hiz), 81'(cap[k] != `OP_SAMPLE));
      dr(80'(io_ring), RL, RL + 8);
    end
    load_ir(`OP_IDENT);
    dr(80'(id_exp), `IDENT_LEN, 34);
    load_ir(`OP_BYPASS);
    do_reset();
    dr(80'(id_exp), `IDENT_LEN, 33);
    for (int w = 0; w < 100 && exp_q.size() != 0; w++)
      #10;
    if (exp_q.size() != 0)
      failures++;
    give_verdict();
  end

endmodule : sram_tap_tb
